/* File: interrupt_and_fault_flag_cmds.sv */
// interrupt and fault-flag command execution for the program interpreter
// assumes host bytes, program instructions, fault events and interrupt
// requests all come from logic on REF_CLK; the interpreter applies
// PC_LOAD and CTX_RESTORE at an instruction boundary

`timescale 1ns/1ps

module interrupt_and_fault_flag_cmds
    import irq_cmd_pkg::*;
#(
    parameter int NUM_IRQ = 32,
    parameter int PC_W    = 16,
    parameter int FLAGS_W = 8
) (
    input  wire logic                  REF_CLK,
    input  wire logic                  SYS_RST,
    input  wire logic [7:0]            MODULE_ADDR,
    input  wire logic [7:0]            CMD_BYTE,
    input  wire logic                  CMD_BYTE_VALID,
    output      logic                  CMD_BYTE_READY,
    output      logic                  REPLY_VALID,
    output      logic [7:0]            REPLY_STATUS,
    output      logic [7:0]            REPLY_OPCODE,
    input  wire logic                  PROG_VALID,
    output      logic                  PROG_READY,
    input  wire logic [7:0]            PROG_OPCODE,
    input  wire logic [7:0]            PROG_TYPE,
    input  wire logic [31:0]           PROG_VALUE,
    input  wire logic [NUM_FAULTS-1:0] FAULT_EVENT,
    output      logic [NUM_FAULTS-1:0] FAULT_FLAGS,
    input  wire logic [NUM_IRQ-1:0]    IRQ_REQ,
    output      logic [NUM_IRQ-1:0]    IRQ_ENABLE,
    output      logic [NUM_IRQ-1:0]    IRQ_PENDING,
    output      logic                  GLOBAL_IRQ_EN,
    output      logic                  IN_HANDLER,
    input  wire logic                  INSTR_BOUNDARY,
    input  wire logic [31:0]           ACCU_IN,
    input  wire logic [31:0]           XREG_IN,
    input  wire logic [FLAGS_W-1:0]    FLAGS_IN,
    input  wire logic [PC_W-1:0]       PC_IN,
    output      logic                  PC_LOAD,
    output      logic                  CTX_RESTORE,
    output      logic [31:0]           ACCU_OUT,
    output      logic [31:0]           XREG_OUT,
    output      logic [FLAGS_W-1:0]    FLAGS_OUT,
    output      logic [PC_W-1:0]       PC_OUT
);

    localparam int IRQ_AW = (NUM_IRQ > 1) ? $clog2(NUM_IRQ) : 1;

    // ------------
    // elaboration checks
    // ------------
    // 255 is the global number, so at most 255 individual sources
    if (NUM_IRQ < 1 || NUM_IRQ > 255) begin : g_bad_irq
        $error("NUM_IRQ must be 1..255");
    end
    if (PC_W < 1 || PC_W > 32) begin : g_bad_pc
        $error("PC_W must be 1..32");
    end

    // ------------
    // decode helpers
    // ------------
    function automatic logic irq_num_ok(input logic [7:0] num);
        irq_num_ok = (32'(num) < NUM_IRQ);
    endfunction

    function automatic logic [NUM_FAULTS-1:0] fault_mask(input logic [7:0] typ);
        logic [NUM_FAULTS-1:0] m;
        m = '0;
        case (typ)
            FCLR_ALL:       m = '1;
            FCLR_TIMEOUT:   m[FB_TIMEOUT]   = 1'b1;
            FCLR_ALARM:     m[FB_ALARM]     = 1'b1;
            FCLR_DEVIATION: m[FB_DEVIATION] = 1'b1;
            FCLR_POSITION:  m[FB_POSITION]  = 1'b1;
            FCLR_SHUTDOWN:  m[FB_SHUTDOWN]  = 1'b1;
            default:        m = '0;
        endcase
        fault_mask = m;
    endfunction

    function automatic logic [IRQ_AW-1:0] lowest_set(input logic [NUM_IRQ-1:0] v);
        logic [IRQ_AW-1:0] r;
        r = '0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = IRQ_AW'(i);
            end
        end
        lowest_set = r;
    endfunction

    // ------------
    // frame receiver and vector store
    // ------------
    logic        frm_valid;
    logic        frm_ready;
    logic [7:0]  frm_addr;
    logic [7:0]  frm_op;
    logic [7:0]  frm_type;
    logic [7:0]  frm_bank;
    logic [31:0] frm_value;
    logic        frm_csum_ok;

    cmd_frame_rx u_rx (
        .clk         (REF_CLK),
        .rst         (SYS_RST),
        .byte_data   (CMD_BYTE),
        .byte_valid  (CMD_BYTE_VALID),
        .byte_ready  (CMD_BYTE_READY),
        .frm_valid   (frm_valid),
        .frm_ready   (frm_ready),
        .frm_addr    (frm_addr),
        .frm_op      (frm_op),
        .frm_type    (frm_type),
        .frm_bank    (frm_bank),
        .frm_value   (frm_value),
        .frm_csum_ok (frm_csum_ok)
    );

    logic              vec_wr;
    logic [IRQ_AW-1:0] vec_wr_addr;
    logic [PC_W-1:0]   vec_wr_data;
    logic              vec_rd;
    logic [IRQ_AW-1:0] vec_rd_addr;
    logic [PC_W-1:0]   vec_rd_data;

    handler_vector_mem #(
        .DEPTH  (NUM_IRQ),
        .WIDTH  (PC_W),
        .ADDR_W (IRQ_AW)
    ) u_vec (
        .clk     (REF_CLK),
        .wr_en   (vec_wr),
        .wr_addr (vec_wr_addr),
        .wr_data (vec_wr_data),
        .rd_en   (vec_rd),
        .rd_addr (vec_rd_addr),
        .rd_data (vec_rd_data)
    );

    // ------------
    // state
    // ------------
    vf_state_type          st_r,     st_nxt;
    logic [NUM_FAULTS-1:0] fault_r,  fault_nxt;
    logic [NUM_IRQ-1:0]    en_r,     en_nxt;
    logic [NUM_IRQ-1:0]    pend_r,   pend_nxt;
    logic                  gen_r,    gen_nxt;
    logic                  isr_r,    isr_nxt;
    logic [31:0]           s_acc_r,  s_acc_nxt;
    logic [31:0]           s_x_r,    s_x_nxt;
    logic [FLAGS_W-1:0]    s_fl_r,   s_fl_nxt;
    logic [PC_W-1:0]       s_pc_r,   s_pc_nxt;
    logic                  pcl_r,    pcl_nxt;
    logic                  rst_r,    rst_nxt;
    logic [PC_W-1:0]       pc_o_r,   pc_o_nxt;
    logic                  rpv_r,    rpv_nxt;
    logic [7:0]            rps_r,    rps_nxt;
    logic [7:0]            rpo_r,    rpo_nxt;

    logic              entry_go;
    logic              accept;
    logic              from_host;
    logic              exec;
    logic [7:0]        c_op;
    logic [7:0]        c_type;
    logic [31:0]       c_value;
    logic [7:0]        status;
    logic [NUM_IRQ-1:0] pend_clr;
    logic [NUM_IRQ-1:0] set_en;
    logic [NUM_IRQ-1:0] clr_en;
    logic [IRQ_AW-1:0] sel_irq;

    // an interrupt only starts between instructions and never nests
    assign sel_irq  = lowest_set(pend_r & en_r);
    assign entry_go = (st_r == VF_IDLE) && gen_r && !isr_r && INSTR_BOUNDARY
                      && |(pend_r & en_r);
    // host frames win over program instructions; both wait during a fetch
    assign accept     = (st_r == VF_IDLE) && !entry_go;
    assign frm_ready  = accept;
    assign PROG_READY = accept && !frm_valid;
    assign from_host  = frm_valid;
    assign c_op       = from_host ? frm_op    : PROG_OPCODE;
    assign c_type     = from_host ? frm_type  : PROG_TYPE;
    assign c_value    = from_host ? frm_value : PROG_VALUE;
    // frames for another module address are dropped without a reply
    assign exec = accept && ((from_host && frm_addr == MODULE_ADDR && frm_csum_ok)
                  || (!from_host && PROG_VALID));

    // ------------
    // pending requests, one sticky bit per source
    // ------------
    for (genvar g = 0; g < NUM_IRQ; g++) begin : g_pend
        // a request in the clearing cycle survives
        assign pend_nxt[g] = (pend_r[g] & ~pend_clr[g]) | IRQ_REQ[g];
        assign pend_clr[g] = entry_go && (sel_irq == IRQ_AW'(g));
        assign set_en[g]   = exec && c_op == OP_INTERRUPT_ON
                             && c_type == 8'(g);
        assign clr_en[g]   = exec && c_op == OP_INTERRUPT_OFF
                             && c_type == 8'(g);
    end

    // ------------
    // command execution
    // ------------
    always_comb begin
        st_nxt    = st_r;
        // set wins over clear for fault events
        fault_nxt = fault_r | FAULT_EVENT;
        en_nxt    = (en_r | set_en) & ~clr_en;
        gen_nxt   = gen_r;
        isr_nxt   = isr_r;
        s_acc_nxt = s_acc_r;
        s_x_nxt   = s_x_r;
        s_fl_nxt  = s_fl_r;
        s_pc_nxt  = s_pc_r;
        pcl_nxt   = 1'b0;
        rst_nxt   = 1'b0;
        pc_o_nxt  = pc_o_r;
        rpv_nxt   = 1'b0;
        rps_nxt   = rps_r;
        rpo_nxt   = rpo_r;
        vec_wr    = 1'b0;
        vec_rd    = 1'b0;
        vec_rd_addr = sel_irq;
        vec_wr_addr = c_type[IRQ_AW-1:0];
        vec_wr_data = c_value[PC_W-1:0];
        status    = ST_OK;

        // bank field is never looked at here; value is only used as the handler address
        case (c_op)
            OP_FAULT_CLEAR: begin
                if (c_type > FCLR_SHUTDOWN) begin
                    status = ST_BAD_TYPE;
                end else if (exec) begin
                    fault_nxt = (fault_r & ~fault_mask(c_type)) | FAULT_EVENT;
                end
            end
            OP_INTERRUPT_ON: begin
                if (c_type == IRQ_GLOBAL_NUM) begin
                    gen_nxt = gen_r | exec;
                end else if (!irq_num_ok(c_type)) begin
                    status = ST_BAD_TYPE;
                end
            end
            OP_INTERRUPT_OFF: begin
                if (c_type == IRQ_GLOBAL_NUM) begin
                    gen_nxt = gen_r & ~exec;
                end else if (!irq_num_ok(c_type)) begin
                    status = ST_BAD_TYPE;
                end
            end
            OP_HANDLER_DEF: begin
                if (!irq_num_ok(c_type)) begin
                    status = ST_BAD_TYPE;
                end else begin
                    vec_wr = exec;
                end
            end
            OP_HANDLER_RET: begin
                // a return outside a handler has no saved context to use
                if (!isr_r) begin
                    status = ST_NOT_IN_ISR;
                end else if (exec) begin
                    rst_nxt  = 1'b1;
                    pc_o_nxt = s_pc_r;
                    isr_nxt  = 1'b0;
                end
            end
            default: begin
                status = ST_BAD_CMD;
            end
        endcase

        // reply only for frames addressed to this module
        if (accept && from_host && frm_addr == MODULE_ADDR) begin
            rpv_nxt = 1'b1;
            rps_nxt = frm_csum_ok ? status : ST_BAD_CSUM;
            rpo_nxt = frm_op;
        end

        case (st_r)
            VF_IDLE: begin
                if (entry_go) begin
                    vec_rd    = 1'b1;
                    isr_nxt   = 1'b1;
                    s_acc_nxt = ACCU_IN;
                    s_x_nxt   = XREG_IN;
                    s_fl_nxt  = FLAGS_IN;
                    s_pc_nxt  = PC_IN;
                    st_nxt    = VF_FETCH;
                end
            end
            VF_FETCH: begin
                pcl_nxt  = 1'b1;
                pc_o_nxt = vec_rd_data;
                st_nxt   = VF_IDLE;
            end
            default: begin
                st_nxt = VF_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_r    <= VF_IDLE;
            fault_r <= FAULT_RESET;
            en_r    <= '0;
            pend_r  <= '0;
            gen_r   <= 1'b0;
            isr_r   <= 1'b0;
            s_acc_r <= 32'h0000_0000;
            s_x_r   <= 32'h0000_0000;
            s_fl_r  <= '0;
            s_pc_r  <= '0;
            pcl_r   <= 1'b0;
            rst_r   <= 1'b0;
            pc_o_r  <= '0;
            rpv_r   <= 1'b0;
            rps_r   <= 8'h00;
            rpo_r   <= 8'h00;
        end else begin
            st_r    <= st_nxt;
            fault_r <= fault_nxt;
            en_r    <= en_nxt;
            pend_r  <= pend_nxt;
            gen_r   <= gen_nxt;
            isr_r   <= isr_nxt;
            s_acc_r <= s_acc_nxt;
            s_x_r   <= s_x_nxt;
            s_fl_r  <= s_fl_nxt;
            s_pc_r  <= s_pc_nxt;
            pcl_r   <= pcl_nxt;
            rst_r   <= rst_nxt;
            pc_o_r  <= pc_o_nxt;
            rpv_r   <= rpv_nxt;
            rps_r   <= rps_nxt;
            rpo_r   <= rpo_nxt;
        end
    end

    // ------------
    // outputs
    // ------------
    assign FAULT_FLAGS   = fault_r;
    assign IRQ_ENABLE    = en_r;
    assign IRQ_PENDING   = pend_r;
    assign GLOBAL_IRQ_EN = gen_r;
    assign IN_HANDLER    = isr_r;
    assign PC_LOAD       = pcl_r;
    assign CTX_RESTORE   = rst_r;
    assign PC_OUT        = pc_o_r;
    assign ACCU_OUT      = s_acc_r;
    assign XREG_OUT      = s_x_r;
    assign FLAGS_OUT     = s_fl_r;
    assign REPLY_VALID   = rpv_r;
    assign REPLY_STATUS  = rps_r;
    assign REPLY_OPCODE  = rpo_r;

endmodule // interrupt_and_fault_flag_cmds

/* File: irq_cmd_pkg.sv */
// constants for the interrupt and fault-flag command block
// assumes one clock domain; every consumer imports the whole package

package irq_cmd_pkg;

    // ------------
    // opcodes
    // ------------
    localparam logic [7:0] OP_FAULT_CLEAR   = 8'h24;
    localparam logic [7:0] OP_INTERRUPT_ON  = 8'h19;
    localparam logic [7:0] OP_INTERRUPT_OFF = 8'h1a;
    localparam logic [7:0] OP_HANDLER_DEF   = 8'h25;
    localparam logic [7:0] OP_HANDLER_RET   = 8'h26;

    // ------------
    // type field codes
    // ------------
    localparam logic [7:0] IRQ_GLOBAL_NUM    = 8'hff;
    localparam logic [7:0] FCLR_ALL          = 8'h00;
    localparam logic [7:0] FCLR_TIMEOUT      = 8'h01;
    localparam logic [7:0] FCLR_ALARM        = 8'h02;
    localparam logic [7:0] FCLR_DEVIATION    = 8'h03;
    localparam logic [7:0] FCLR_POSITION     = 8'h04;
    localparam logic [7:0] FCLR_SHUTDOWN     = 8'h05;

    // ------------
    // fault flag bit positions
    // ------------
    localparam int NUM_FAULTS    = 5;
    localparam int FB_TIMEOUT    = 0;
    localparam int FB_ALARM      = 1;
    localparam int FB_DEVIATION  = 2;
    localparam int FB_POSITION   = 3;
    localparam int FB_SHUTDOWN   = 4;
    localparam logic [NUM_FAULTS-1:0] FAULT_RESET = 5'h00;

    // ------------
    // command frame layout and reply status
    // ------------
    localparam int          FRAME_BYTES     = 9;
    localparam logic [3:0]  FRAME_LAST_IDX  = 4'h8;
    localparam logic [7:0]  ST_OK           = 8'h64;
    localparam logic [7:0]  ST_BAD_CSUM     = 8'h01;
    localparam logic [7:0]  ST_BAD_CMD      = 8'h02;
    localparam logic [7:0]  ST_BAD_TYPE     = 8'h03;
    localparam logic [7:0]  ST_NOT_IN_ISR   = 8'h06;

    // ------------
    // vector fetch sequencer
    // ------------
    typedef enum logic [1:0] {
        VF_IDLE  = 2'b01,
        VF_FETCH = 2'b10
    } vf_state_type;

endpackage : irq_cmd_pkg

/* File: handler_vector_mem.sv */
// handler entry address store, one word per interrupt number
// assumes a single clock; read data is registered, one cycle after rd_en

`timescale 1ns/1ps

module handler_vector_mem #(
    parameter int DEPTH  = 32,
    parameter int WIDTH  = 16,
    parameter int ADDR_W = 5
) (
    input  wire logic              clk,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]  wr_data,
    input  wire logic              rd_en,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output      logic [WIDTH-1:0]  rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    if ((1 << ADDR_W) < DEPTH) begin : g_bad_addr
        $error("handler_vector_mem: ADDR_W too small for DEPTH");
    end

    // no reset on the array so it maps to ram; contents undefined until defined
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule // handler_vector_mem

/* File: cmd_frame_rx.sv */
// assembles nine-byte command frames and checks their checksum
// assumes bytes arrive from logic on the same clock with a valid/ready pair

`timescale 1ns/1ps

module cmd_frame_rx
    import irq_cmd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  byte_data,
    input  wire logic        byte_valid,
    output      logic        byte_ready,
    output      logic        frm_valid,
    input  wire logic        frm_ready,
    output      logic [7:0]  frm_addr,
    output      logic [7:0]  frm_op,
    output      logic [7:0]  frm_type,
    output      logic [7:0]  frm_bank,
    output      logic [31:0] frm_value,
    output      logic        frm_csum_ok
);

    logic [3:0]  idx_r,  idx_nxt;
    logic [7:0]  sum_r,  sum_nxt;
    logic        full_r, full_nxt;
    logic        ok_r,   ok_nxt;
    logic [7:0]  buf_r   [FRAME_BYTES-1];
    logic [7:0]  buf_nxt [FRAME_BYTES-1];

    // a held frame stalls the byte stream until the command is taken
    assign byte_ready  = !full_r;
    assign frm_valid   = full_r;
    assign frm_csum_ok = ok_r;
    assign frm_addr    = buf_r[0];
    assign frm_op      = buf_r[1];
    assign frm_type    = buf_r[2];
    assign frm_bank    = buf_r[3];
    assign frm_value   = {buf_r[4], buf_r[5], buf_r[6], buf_r[7]};

    always_comb begin
        idx_nxt  = idx_r;
        sum_nxt  = sum_r;
        full_nxt = full_r;
        ok_nxt   = ok_r;
        buf_nxt  = buf_r;
        if (full_r && frm_ready) begin
            full_nxt = 1'b0;
        end
        if (byte_valid && !full_r) begin
            if (idx_r == FRAME_LAST_IDX) begin
                ok_nxt   = (sum_r == byte_data);
                full_nxt = 1'b1;
                idx_nxt  = 4'h0;
                sum_nxt  = 8'h00;
            end else begin
                buf_nxt[idx_r[2:0]] = byte_data;
                sum_nxt = sum_r + byte_data;
                idx_nxt = idx_r + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idx_r  <= 4'h0;
            sum_r  <= 8'h00;
            full_r <= 1'b0;
            ok_r   <= 1'b0;
            for (int i = 0; i < FRAME_BYTES - 1; i++) begin
                buf_r[i] <= 8'h00;
            end
        end else begin
            idx_r  <= idx_nxt;
            sum_r  <= sum_nxt;
            full_r <= full_nxt;
            ok_r   <= ok_nxt;
            buf_r  <= buf_nxt;
        end
    end

endmodule // cmd_frame_rx

/* File: irq_cmd_props.sv */
// port checks for the interrupt and fault-flag command block
// assumes one clock REF_CLK and the asynchronous active-high reset SYS_RST
`timescale 1ns/1ps
module irq_cmd_props
    import irq_cmd_pkg::*;
#(parameter int NUM_IRQ = 32) (
    input wire logic                  REF_CLK,
    input wire logic                  SYS_RST,
    input wire logic                  PROG_VALID,
    input wire logic                  PROG_READY,
    input wire logic [7:0]            PROG_OPCODE,
    input wire logic [7:0]            PROG_TYPE,
    input wire logic [NUM_FAULTS-1:0] FAULT_EVENT,
    input wire logic [NUM_FAULTS-1:0] FAULT_FLAGS,
    input wire logic [NUM_IRQ-1:0]    IRQ_ENABLE,
    input wire logic [NUM_IRQ-1:0]    IRQ_PENDING,
    input wire logic                  GLOBAL_IRQ_EN,
    input wire logic                  IN_HANDLER,
    input wire logic                  INSTR_BOUNDARY,
    input wire logic                  PC_LOAD,
    input wire logic                  CTX_RESTORE
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    wire take = PROG_VALID && PROG_READY;
    sequence entry_cond;
        GLOBAL_IRQ_EN && !IN_HANDLER && INSTR_BOUNDARY && |(IRQ_PENDING & IRQ_ENABLE);
    endsequence
    sequence entry_resp;
        IN_HANDLER ##1 PC_LOAD;
    endsequence
    // the number is held in a local so a later type change cannot hide a miss
    property single_p(logic [7:0] op, logic val);
        int n;
        (take && PROG_OPCODE == op && PROG_TYPE < NUM_IRQ, n = PROG_TYPE) |=> IRQ_ENABLE[n] == val;
    endproperty
    irq_on_a: assert property (single_p(OP_INTERRUPT_ON, 1'b1))
        else $error("single enable not set");
    irq_off_a: assert property (single_p(OP_INTERRUPT_OFF, 1'b0))
        else $error("single enable not cleared");
    glob_on_a: assert property (take && PROG_OPCODE == OP_INTERRUPT_ON && PROG_TYPE == 8'hff |=> GLOBAL_IRQ_EN)
        else $error("global enable not set");
    glob_off_a: assert property (take && PROG_OPCODE == OP_INTERRUPT_OFF && PROG_TYPE == 8'hff |=> !GLOBAL_IRQ_EN)
        else $error("global enable not cleared");
    fault_clear_a: assert property (take && PROG_OPCODE == OP_FAULT_CLEAR && PROG_TYPE == 8'h00 |=> FAULT_FLAGS == $past(FAULT_EVENT))
        else $error("fault flags not cleared");
    entry_jump_a: assert property (entry_cond |=> entry_resp)
        else $error("interrupt entry missed");
    glob_gate_a: assert property ((!GLOBAL_IRQ_EN && !IN_HANDLER) [*2] |=> !PC_LOAD)
        else $error("handler entered while globally disabled");
    ret_restore_a: assert property (take && PROG_OPCODE == OP_HANDLER_RET && IN_HANDLER |=> CTX_RESTORE && !IN_HANDLER)
        else $error("return did not restore context");
    ret_outside_a: assert property (take && PROG_OPCODE == OP_HANDLER_RET && !IN_HANDLER |=> !CTX_RESTORE)
        else $error("restore outside a handler");
endmodule // irq_cmd_props
bind interrupt_and_fault_flag_cmds irq_cmd_props #(.NUM_IRQ(NUM_IRQ)) u_props (
    .REF_CLK, .SYS_RST, .PROG_VALID, .PROG_READY, .PROG_OPCODE, .PROG_TYPE, .FAULT_EVENT,
    .FAULT_FLAGS, .IRQ_ENABLE, .IRQ_PENDING, .GLOBAL_IRQ_EN, .IN_HANDLER, .INSTR_BOUNDARY,
    .PC_LOAD, .CTX_RESTORE
);

/* File: host_frame_src.sv */
// host model sending nine-byte command frames over the byte handshake
// assumes byte ready only changes on the rising edge of clk
`timescale 1ns/1ps
module host_frame_src (
    input  wire logic       clk,
    input  wire logic       byte_ready,
    output      logic [7:0] byte_data,
    output      logic       byte_valid
);
    initial begin
        byte_data  = 8'h00;
        byte_valid = 1'b0;
    end
    // bank byte is a nonzero don't-care so a block that reads it gets caught
    task automatic send(input logic [7:0] adr, op, ty, input logic [31:0] v,
                        input logic [7:0] flip);
        logic [7:0] f[9];
        f = '{adr, op, ty, 8'h3c, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
        for (int i = 0; i < 8; i++) f[8] += f[i];
        f[8] ^= flip;
        for (int i = 0; i < 9; i++) begin
            @(negedge clk);
            byte_data  <= f[i];
            byte_valid <= 1'b1;
            #1;
            while (byte_ready !== 1'b1) begin
                @(negedge clk);
                #1;
            end
            @(posedge clk);
        end
        @(negedge clk);
        byte_valid <= 1'b0;
        byte_data  <= ~f[8]; // released line must not keep the last byte
    endtask
endmodule // host_frame_src

/* File: interrupt_and_fault_flag_cmds_tb_top.sv */
// self-checking bench for the interrupt and fault-flag command block
// assumes the host model and the checker are compiled before it
`timescale 1ns/1ps
module interrupt_and_fault_flag_cmds_tb_top;
    import irq_cmd_pkg::*;
    localparam logic [7:0] MY_ADDR = 8'h01;
    logic REF_CLK = 0, SYS_RST = 1, PROG_VALID = 0, INSTR_BOUNDARY = 1, CMD_BYTE_VALID;
    logic CMD_BYTE_READY, REPLY_VALID, PROG_READY, GLOBAL_IRQ_EN, IN_HANDLER, PC_LOAD, CTX_RESTORE;
    logic [7:0]  CMD_BYTE, REPLY_STATUS, REPLY_OPCODE, PROG_OPCODE = 0, PROG_TYPE = 0;
    logic [31:0] PROG_VALUE = 0, ACCU_IN = 0, XREG_IN = 0, ACCU_OUT, XREG_OUT;
    logic [31:0] IRQ_REQ = 0, IRQ_ENABLE, IRQ_PENDING;
    logic [4:0]  FAULT_EVENT = 0, FAULT_FLAGS;
    logic [7:0]  FLAGS_IN = 0, FLAGS_OUT;
    logic [15:0] PC_IN = 0, PC_OUT;
    int          errors = 0, n_compared = 0, cycles = 0;
    interrupt_and_fault_flag_cmds uut (
        .REF_CLK, .SYS_RST, .MODULE_ADDR(MY_ADDR), .CMD_BYTE, .CMD_BYTE_VALID, .CMD_BYTE_READY,
        .REPLY_VALID, .REPLY_STATUS, .REPLY_OPCODE, .PROG_VALID, .PROG_READY, .PROG_OPCODE,
        .PROG_TYPE, .PROG_VALUE, .FAULT_EVENT, .FAULT_FLAGS, .IRQ_REQ, .IRQ_ENABLE, .IRQ_PENDING,
        .GLOBAL_IRQ_EN, .IN_HANDLER, .INSTR_BOUNDARY, .ACCU_IN, .XREG_IN, .FLAGS_IN, .PC_IN,
        .PC_LOAD, .CTX_RESTORE, .ACCU_OUT, .XREG_OUT, .FLAGS_OUT, .PC_OUT
    );
    host_frame_src host (.clk(REF_CLK), .byte_ready(CMD_BYTE_READY), .byte_data(CMD_BYTE),
                         .byte_valid(CMD_BYTE_VALID));
    initial forever #2 REF_CLK = ~REF_CLK;
    task automatic chk(input string what, input logic [31:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic frame(input logic [7:0] op, ty, input logic [31:0] v, input logic [7:0] flip, st);
        host.send(MY_ADDR, op, ty, v, flip);
        for (int i = 0; i < 20 && REPLY_VALID !== 1'b1; i++) @(negedge REF_CLK);
        chk("reply status", st, REPLY_STATUS);
        chk("reply opcode", op, REPLY_OPCODE);
        @(negedge REF_CLK);
    endtask
    task automatic prog(input logic [7:0] op, ty, input logic [31:0] v);
        @(negedge REF_CLK);
        PROG_OPCODE <= op;
        PROG_TYPE <= ty;
        PROG_VALUE <= v;
        PROG_VALID <= 1'b1;
        #1;
        while (PROG_READY !== 1'b1) begin
            @(negedge REF_CLK);
            #1;
        end
        @(posedge REF_CLK);
        @(negedge REF_CLK);
        PROG_VALID <= 1'b0;
    endtask
    task automatic t_fault;
        for (int t = 0; t <= 6; t++) begin
            @(negedge REF_CLK) FAULT_EVENT <= 5'h1f;
            @(negedge REF_CLK) FAULT_EVENT <= 5'h00;
            if (t < 6) frame(OP_FAULT_CLEAR, t[7:0], 32'h0000_00a5, 8'h00, ST_OK);
            else prog(OP_FAULT_CLEAR, FCLR_ALL, 32'h0);
            @(negedge REF_CLK);
            chk("fault flags", t % 6 == 0 ? 32'h0 : 32'h1f & ~(32'h1 << (t - 1)), FAULT_FLAGS);
        end
        $display("fault clear test done");
    endtask
    task automatic t_enable;
        frame(OP_INTERRUPT_ON, 8'h03, 32'hffff_ffff, 8'h00, ST_OK);
        chk("enables", 32'h8, IRQ_ENABLE);
        frame(OP_INTERRUPT_ON, IRQ_GLOBAL_NUM, 32'h0, 8'h00, ST_OK);
        chk("global enable", 32'h1, GLOBAL_IRQ_EN);
        chk("enables", 32'h8, IRQ_ENABLE);
        frame(OP_INTERRUPT_OFF, 8'h03, 32'h0000_0005, 8'h00, ST_OK);
        chk("enables", 32'h0, IRQ_ENABLE);
        frame(OP_INTERRUPT_OFF, IRQ_GLOBAL_NUM, 32'h0, 8'h00, ST_OK);
        chk("global enable", 32'h0, GLOBAL_IRQ_EN);
        frame(OP_INTERRUPT_ON, 8'h05, 32'h0, 8'h01, ST_BAD_CSUM);
        chk("enables", 32'h0, IRQ_ENABLE);
        frame(OP_INTERRUPT_ON, 8'h40, 32'h0, 8'h00, ST_BAD_TYPE);
        $display("enable test done");
    endtask
    task automatic t_entry;
        prog(OP_HANDLER_DEF, 8'h02, 32'h0000_0100);
        prog(OP_HANDLER_DEF, 8'h02, 32'h0000_0234);
        prog(OP_INTERRUPT_ON, 8'h02, 32'h0);
        prog(OP_INTERRUPT_ON, IRQ_GLOBAL_NUM, 32'h0);
        ACCU_IN <= 32'h1234_5678;
        XREG_IN <= 32'h9abc_def0;
        FLAGS_IN <= 8'h5a;
        PC_IN <= 16'h0042;
        IRQ_REQ <= 32'h4;
        @(negedge REF_CLK) IRQ_REQ <= 32'h0;
        for (int i = 0; i < 20 && PC_LOAD !== 1'b1; i++) @(negedge REF_CLK);
        chk("handler entry", 32'h0234, PC_OUT);
        chk("in handler", 32'h1, IN_HANDLER);
        chk("pending", 32'h0, IRQ_PENDING);
        ACCU_IN <= 32'h0;
        XREG_IN <= 32'h0;
        FLAGS_IN <= 8'h00;
        PC_IN <= 16'h0300;
        prog(OP_HANDLER_RET, IRQ_GLOBAL_NUM, 32'h0);
        for (int i = 0; i < 20 && CTX_RESTORE !== 1'b1; i++) @(negedge REF_CLK);
        chk("accu", 32'h1234_5678, ACCU_OUT);
        chk("xreg", 32'h9abc_def0, XREG_OUT);
        chk("flags", 32'h5a, FLAGS_OUT);
        chk("pc", 32'h0042, PC_OUT);
        prog(OP_HANDLER_RET, IRQ_GLOBAL_NUM, 32'h0);
        prog(OP_INTERRUPT_OFF, 8'h02, 32'h0);
        prog(OP_INTERRUPT_OFF, IRQ_GLOBAL_NUM, 32'h0);
        @(negedge REF_CLK);
        chk("in handler", 32'h0, IN_HANDLER);
        chk("global enable", 32'h0, GLOBAL_IRQ_EN);
        $display("interrupt entry test done");
    endtask
    initial begin
        repeat (8) @(negedge REF_CLK);
        SYS_RST <= 1'b0;
        @(negedge REF_CLK);
        t_fault;
        t_enable;
        t_entry;
        report_and_stop;
    end
    // ceiling far above test length
    always @(posedge REF_CLK) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            report_and_stop;
        end
    end
endmodule // interrupt_and_fault_flag_cmds_tb_top
